// ---- verilog/tdm_switch_params.svh ----
`ifndef TDM_SWITCH_PARAMS_SVH
`define TDM_SWITCH_PARAMS_SVH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define TSW_CTRL_OFS 14'h0000
`define TSW_STAT_OFS 14'h0004
`define TSW_CONN_BASE 14'h2000
`define TSW_CTRL_RST 2'h2

// ----------------------------------------------------------------
// connection entry fields
// ----------------------------------------------------------------
`define TSW_CHANNEL_LOOPBACK_BIT 15
`define TSW_DLY_BIT 14
`define TSW_MSG_BIT 13
`define TSW_AUX_BIT 12
`define TSW_OE_BIT 11
`define TSW_SRC_MSB 10
`define TSW_SRC_LSB 7
`define TSW_CHN_MSB 6
`define TSW_MSGB_MSB 7

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TSW_CLK_NS 10
`define TSW_BIT_NS 122
`define TSW_BIT_CYC (`TSW_BIT_NS / `TSW_CLK_NS)

`endif

// ---- verilog/tdm_switch_pkg.sv ----
package tdm_switch_pkg;
  typedef enum logic [1:0] {
    RATE_2M = 2'h0,
    RATE_4M = 2'h1,
    RATE_8M = 2'h2
  } rate_t;
endpackage

// ---- verilog/entry_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface entry_if #(parameter int NS = 16, parameter int CW = 7);
  logic [1:0] rate;
  logic [15:0] raw [NS];
  logic [NS-1:0] channel_loopback;
  logic [NS-1:0] constDly;
  logic [NS-1:0] msg;
  logic [NS-1:0] oe;
  logic [3:0] srcStream [NS];
  logic [CW-1:0] srcChan [NS];
  logic [7:0] msgByte [NS];
  modport dec (input rate, raw, output channel_loopback, constDly, msg, oe, srcStream,
    srcChan, msgByte);
  modport use_side (output rate, raw, input channel_loopback, constDly, msg, oe,
    srcStream, srcChan, msgByte);
endinterface
`default_nettype wire

// ---- verilog/pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tdm_switch_params.svh"
module pin_sync #(parameter int W = 16) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] level
);
  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q;
  logic [W-1:0] lvl_d;

  // a change counts only once stages two and three agree
  always_comb begin
    lvl_d = lvl_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        lvl_d[i] = s2_q[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end else begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level = lvl_q;
endmodule
`default_nettype wire

// ---- verilog/entry_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tdm_switch_params.svh"
module entry_decode #(parameter int NS = 16, parameter int CW = 7) (
  entry_if.dec e
);
  // unused high channel bits read as zero so lower rates never alias
  always_comb begin
    for (int n = 0; n < NS; n++) begin
      e.channel_loopback[n] = e.raw[n][`TSW_CHANNEL_LOOPBACK_BIT];
      e.constDly[n] = e.raw[n][`TSW_DLY_BIT];
      e.msg[n] = e.raw[n][`TSW_MSG_BIT];
      e.oe[n] = e.raw[n][`TSW_OE_BIT];
      e.srcStream[n] = e.raw[n][`TSW_SRC_MSB:`TSW_SRC_LSB];
      e.msgByte[n] = e.raw[n][`TSW_MSGB_MSB:0];
      e.srcChan[n] = e.raw[n][CW-1:0];
      case (e.rate)
        tdm_switch_pkg::RATE_2M: e.srcChan[n][CW-1:5] = '0;
        tdm_switch_pkg::RATE_4M: e.srcChan[n][CW-1:6] = '0;
        default: e.srcChan[n] = e.raw[n][CW-1:0];
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- verilog/tdm_switch_connection_entry.sv ----
// How it works
// - bit 15 loops output channel back to input
// - bit 14 picks variable or constant delay
// - bit 13 sends entry low byte instead
// - bit 13 clear: entry addresses data memory
// - bit 12 on aux pin one channel early
// - bit 11 enables output driver per slot
// - bits 10..7 give source stream number
// - bits 6..0 give source channel number
// - only channel bits the rate needs used
`timescale 1ns/1ps
`default_nettype none
`include "tdm_switch_params.svh"
module tdm_switch_connection_entry #(
  parameter int NS = 16,
  parameter int NC = 128,
  parameter int BIT_CYC = `TSW_BIT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NS-1:0] serial_input_line,
  output logic [NS-1:0] serial_output_line,
  output logic [NS-1:0] serial_output_oe,
  output logic aux_control_output,
  output logic frameStart
);
  localparam int CW = $clog2(NC);
  localparam int SW = $clog2(NS);
  localparam int IW = SW + CW;
  localparam int AW = IW + 1;
  localparam int TW = $clog2(BIT_CYC + 1);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rstSync_q;
  logic rstN;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_q <= 2'h0;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstN = rstSync_q[1];

  logic [NS-1:0] inLevel;
  pin_sync #(.W(NS)) u_sync (
    .clk(clk),
    .rstN(rstN),
    .pinIn(serial_input_line),
    .level(inLevel)
  );

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [15:0] connMem_q [2**IW];
  logic [15:0] connMem_d [2**IW];
  logic [7:0] dataMem_q [2**AW];
  logic [7:0] dataMem_d [2**AW];
  logic [1:0] rate_q, rate_d;

  entry_if #(.NS(NS), .CW(CW)) dec ();
  entry_decode #(.NS(NS), .CW(CW)) u_dec (.e(dec));

  // ----------------------------------------------------------------
  // slot timing
  // ----------------------------------------------------------------
  logic [TW-1:0] cyc_q, cyc_d;
  logic [2:0] bit_q, bit_d;
  logic [CW-1:0] chan_q, chan_d;
  logic bank_q, bank_d;
  logic bitTick, halfTick, slotEnd, frameEnd;
  logic [CW-1:0] chanLim, chanNext, chanAux;

  always_comb begin
    case (rate_q)
      tdm_switch_pkg::RATE_2M: chanLim = CW'(31);
      tdm_switch_pkg::RATE_4M: chanLim = CW'(63);
      default: chanLim = CW'(NC - 1);
    endcase
    bitTick = (cyc_q == TW'(BIT_CYC - 1));
    halfTick = bitTick || (cyc_q == TW'(BIT_CYC / 2 - 1));
    slotEnd = bitTick && (bit_q == 3'h7);
    // a rate change mid-frame must not strand the counter
    frameEnd = slotEnd && (chan_q >= chanLim);
    chanNext = frameEnd ? '0 : chan_q + CW'(1);
    chanAux = (chanNext >= chanLim) ? '0 : chanNext + CW'(1);
    cyc_d = bitTick ? '0 : cyc_q + TW'(1);
    bit_d = bitTick ? bit_q + 3'h1 : bit_q;
    chan_d = slotEnd ? chanNext : chan_q;
    bank_d = frameEnd ? ~bank_q : bank_q;
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cyc_q <= '0;
      bit_q <= 3'h0;
      chan_q <= '0;
      bank_q <= 1'b0;
    end else begin
      cyc_q <= cyc_d;
      bit_q <= bit_d;
      chan_q <= chan_d;
      bank_q <= bank_d;
    end
  end

  // ----------------------------------------------------------------
  // switching datapath
  // ----------------------------------------------------------------
  logic [7:0] inSh_q [NS];
  logic [7:0] inSh_d [NS];
  logic [7:0] outSh_q [NS];
  logic [7:0] outSh_d [NS];
  logic [NS-1:0] out_q, out_d, oe_q, oe_d, channel_loopback_q, channel_loopback_d;
  logic [NS-1:0] auxSh_q, auxSh_d, auxVec;
  logic aux_q, aux_d, frame_q, frame_d;
  logic [AW-1:0] rdAddr [NS];
  logic [7:0] newByte [NS];
  logic [NS-1:0] inBit;

  always_comb begin
    dec.rate = rate_q;
    for (int n = 0; n < NS; n++) begin
      dec.raw[n] = connMem_q[{SW'(n), chanNext}];
      // constant delay reads the bank completed in the last frame
      rdAddr[n] = {bank_q ^ dec.constDly[n], dec.srcStream[n][SW-1:0],
        dec.srcChan[n]};
      newByte[n] = dec.msg[n] ? dec.msgByte[n]
        : dataMem_q[rdAddr[n]];
      inBit[n] = channel_loopback_q[n] ? out_q[n] : inLevel[n];
      auxVec[n] = connMem_q[{SW'(n), chanAux}][`TSW_AUX_BIT];
    end
  end

  always_comb begin
    dataMem_d = dataMem_q;
    out_d = out_q;
    oe_d = oe_q;
    channel_loopback_d = channel_loopback_q;
    aux_d = aux_q;
    auxSh_d = auxSh_q;
    frame_d = frameEnd;
    for (int n = 0; n < NS; n++) begin
      inSh_d[n] = inSh_q[n];
      outSh_d[n] = outSh_q[n];
      if (bitTick) begin
        inSh_d[n] = {inSh_q[n][6:0], inBit[n]};
        out_d[n] = outSh_q[n][7];
        outSh_d[n] = {outSh_q[n][6:0], 1'b0};
      end
      if (slotEnd) begin
        dataMem_d[{bank_q, SW'(n), chan_q}] = {inSh_q[n][6:0], inBit[n]};
        out_d[n] = newByte[n][7];
        outSh_d[n] = {newByte[n][6:0], 1'b0};
        oe_d[n] = dec.oe[n];
        channel_loopback_d[n] = dec.channel_loopback[n];
      end
    end
    // aux bits go out two per bit time, stream 0 first
    if (slotEnd) begin
      aux_d = auxVec[0];
      auxSh_d = auxVec >> 1;
    end else if (halfTick) begin
      aux_d = auxSh_q[0];
      auxSh_d = auxSh_q >> 1;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      out_q <= '0;
      oe_q <= '0;
      channel_loopback_q <= '0;
      auxSh_q <= '0;
      aux_q <= 1'b0;
      frame_q <= 1'b0;
      for (int n = 0; n < NS; n++) begin
        inSh_q[n] <= 8'h00;
        outSh_q[n] <= 8'h00;
      end
    end else begin
      out_q <= out_d;
      oe_q <= oe_d;
      channel_loopback_q <= channel_loopback_d;
      auxSh_q <= auxSh_d;
      aux_q <= aux_d;
      frame_q <= frame_d;
      inSh_q <= inSh_d;
      outSh_q <= outSh_d;
    end
  end

  // data memory holds traffic only; it needs no reset
  always_ff @(posedge clk) begin
    dataMem_q <= dataMem_d;
  end

  // ----------------------------------------------------------------
  // apb slave: no wait states, pready from a flop
  // ----------------------------------------------------------------
  logic [31:0] prdata_q, prdata_d, rdVal;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic setup, access, isCtrl, isStat, isConn;
  logic [IW-1:0] connIdx;

  always_comb begin
    setup = psel && !penable;
    access = psel && penable && pready_q;
    isCtrl = (paddr == `TSW_CTRL_OFS);
    isStat = (paddr == `TSW_STAT_OFS);
    isConn = paddr[13] && (paddr[1:0] == 2'h0);
    connIdx = paddr[IW+1:2];
    rdVal = 32'h0000_0000;
    if (isCtrl) begin
      rdVal[1:0] = rate_q;
    end else if (isStat) begin
      rdVal[CW:0] = {bank_q, chan_q};
    end else if (isConn) begin
      rdVal[15:0] = connMem_q[connIdx];
    end
    pready_d = setup;
    pslverr_d = setup && !(isCtrl || isStat || isConn);
    prdata_d = setup ? rdVal : prdata_q;
    rate_d = rate_q;
    connMem_d = connMem_q;
    if (access && pwrite && !pslverr_q) begin
      if (isCtrl) begin
        rate_d = pwdata[1:0];
      end
      if (isConn) begin
        connMem_d[connIdx] = pwdata[15:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      rate_q <= `TSW_CTRL_RST;
      for (int i = 0; i < 2**IW; i++) begin
        connMem_q[i] <= 16'h0000;
      end
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      rate_q <= rate_d;
      connMem_q <= connMem_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign serial_output_line = out_q;
  assign serial_output_oe = oe_q;
  assign aux_control_output = aux_q;
  assign frameStart = frame_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstN);

  property p_loop;
    (bitTick && channel_loopback_q[0]) |=> (inSh_q[0][0] == $past(out_q[0]));
  endproperty
  a_loop: assert property (p_loop) else $error("loopback bit lost");

  property p_const;
    (slotEnd && !dec.msg[0] && dec.constDly[0]) |-> (rdAddr[0][AW-1] != bank_q);
  endproperty
  a_const: assert property (p_const) else $error("bad delay bank");

  property p_msg;
    (slotEnd && dec.msg[0]) |=> (out_q[0] == $past(dec.msgByte[0][7]))
      ##(BIT_CYC) (out_q[0] == $past(dec.msgByte[0][6], BIT_CYC + 1));
  endproperty
  a_msg: assert property (p_msg) else $error("message byte wrong");

  property p_sw;
    (slotEnd && !dec.msg[0]) |=> (out_q[0] == $past(dataMem_q[rdAddr[0]][7]));
  endproperty
  a_sw: assert property (p_sw) else $error("switched byte wrong");

  property p_aux;
    slotEnd |=> (aux_control_output ==
      $past(connMem_q[{SW'(0), chanAux}][`TSW_AUX_BIT]));
  endproperty
  a_aux: assert property (p_aux) else $error("aux bit wrong");

  property p_oe;
    slotEnd |=> (serial_output_oe == $past(dec.oe)) ##1 $stable(oe_q)[*4];
  endproperty
  a_oe: assert property (p_oe) else $error("enable not per slot");

  property p_src;
    (slotEnd && !dec.msg[0]) |->
      (rdAddr[0][AW-2:CW] == dec.raw[0][`TSW_SRC_LSB+SW-1:`TSW_SRC_LSB]);
  endproperty
  a_src: assert property (p_src) else $error("source stream wrong");

  property p_chn;
    (rate_q == tdm_switch_pkg::RATE_8M) |-> (dec.srcChan[0] ==
      dec.raw[0][CW-1:0]);
  endproperty
  a_chn: assert property (p_chn) else $error("source channel wrong");

  property p_rate;
    (rate_q == tdm_switch_pkg::RATE_2M) |->
      (dec.srcChan[0] == {2'h0, dec.raw[0][4:0]});
  endproperty
  a_rate: assert property (p_rate) else $error("channel mask wrong");

  property p_slot;
    (slotEnd && !frameEnd) |=> (chan_q == $past(chan_q) + CW'(1));
  endproperty
  a_slot: assert property (p_slot) else $error("slot skipped");
endmodule
`default_nettype wire

// ---- bench/stream_source.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// far-side serial sources
// ----------------------------------------------------------------
module stream_source #(parameter int NS = 16) (
  output logic [NS-1:0] lines
);
  // even streams sit low, odd ones high: a bit slip cannot
  // change the byte a connection picks up
  always_comb begin
    for (int s = 0; s < NS; s++) begin
      lines[s] = s[0];
    end
  end
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tdm_switch_params.svh"
module testbench;
  localparam int BC = 4;
  logic clk, rst_n, psel, penable, pwrite;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err, aux, fs;
  logic [15:0] sin, sout, soe, auxSeen;
  logic [7:0] outByte [16];
  logic [7:0] oeByte [16];
  logic [15:0] ent [7];
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;

  tdm_switch_connection_entry #(.NS(16), .NC(128), .BIT_CYC(BC))
    tdm_switch_connection_entry_i (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_input_line(sin),
    .serial_output_line(sout), .serial_output_oe(soe),
    .aux_control_output(aux), .frameStart(fs));

  stream_source #(.NS(16)) stream_source_i (.lines(sin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic wrap_up;
    if (errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      wrap_up;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // apb master
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [13:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the bench timeout ends this wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [13:0] ea(input int s, input int c);
    return `TSW_CONN_BASE + 14'(4 * (s * 128 + c));
  endfunction

  // ----------------------------------------------------------------
  // serial side
  // ----------------------------------------------------------------
  task automatic waitFs;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (fs !== 1'b1 && n < 20000);
  endtask

  // channel 0 of every stream, sampled mid-bit; aux mid-stream
  task automatic capture;
    for (int t = 0; t < 32; t++) begin
      if (t % 4 == 2) begin
        for (int s = 0; s < 16; s++) begin
          outByte[s][7 - t / 4] = sout[s];
          oeByte[s][7 - t / 4] = soe[s];
        end
      end
      if (t % 2 == 1) begin
        auxSeen[t / 2] = aux;
      end
      @(posedge clk);
      #1;
    end
  endtask

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 14'h0000;
    pwdata = 32'h0000_0000;
    ent = '{16'h28A5, 16'h205A, 16'hA8A5, 16'h4900, 16'h4920, 16'h0883,
      16'h0989};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, `TSW_CTRL_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
    apb(1'b0, ea(9, 77), 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b1, ea(9, 77), 32'hFFFF_1234);
    apb(1'b0, ea(9, 77), 32'h0000_0000);
    chk(rd, 32'h0000_1234);
    apb(1'b0, 14'h1000, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    // stream 2 loops back only for this diagnostic run
    for (int s = 0; s < 7; s++) begin
      apb(1'b1, ea(s, 0), {16'h0000, ent[s]});
    end
    apb(1'b1, ea(7, 1), 32'h0000_1000);
    for (int r = 2; r >= 0; r--) begin
      apb(1'b1, `TSW_CTRL_OFS, 32'(r));
      apb(1'b0, `TSW_CTRL_OFS, 32'h0000_0000);
      chk(rd, 32'(r));
      waitFs;
      waitFs;
      waitFs;
      chk(32'(n), 32'((32 << r) * 8 * BC));
      waitFs;
      capture;
      chk(32'(outByte[0]), 32'h0000_00A5);
      chk(32'(oeByte[0]), 32'h0000_00FF);
      chk(32'(oeByte[1]), 32'h0000_0000);
      chk(32'(outByte[3]), 32'h0000_00A5);
      chk(32'(outByte[4]), (r == 0) ? 32'h0000_00A5 : 32'h0);
      chk(32'(outByte[5]), 32'h0000_00FF);
      chk(32'(outByte[6]), 32'h0000_00FF);
      chk(32'(auxSeen), 32'h0000_0080);
    end
    wrap_up;
  end
endmodule
`default_nettype wire
